/* File: pkg/mdm_pkg.sv */
// constants for the modem lines and interrupt pin block
`default_nettype none
package mdm_pkg;
    localparam logic [2:0] ADDR_IER = 3'h1;
    localparam logic [2:0] ADDR_IIR = 3'h2;
    localparam logic [2:0] ADDR_MCR = 3'h4;
    localparam logic [2:0] ADDR_MSR = 3'h6;
    localparam logic [2:0] ADDR_SRC = 3'h7;
    localparam logic [2:0] ADDR_IMK = 3'h3;
    // modem status register bit positions
    localparam int MSR_DCTS = 0;
    localparam int MSR_DDSR = 1;
    localparam int MSR_RING_TRAILING_EDGE_FLAG = 2;
    localparam int MSR_DDCD = 3;
    localparam int MSR_CTS  = 4;
    localparam int MSR_DSR  = 5;
    localparam int MSR_RI   = 6;
    localparam int MSR_DCD  = 7;
    // modem control register bit positions
    localparam int MCR_DTR  = 0;
    localparam int MCR_RTS  = 1;
    localparam int MCR_OUTA = 2;
    localparam int MCR_OUTB = 3;
    localparam int MCR_LOOP = 4;
    // interrupt enable bit positions
    localparam int IE_RXDATA = 0;
    localparam int IE_THRE   = 1;
    localparam int IE_RXERR  = 2;
    localparam int IE_MODEM  = 3;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [3:0] IER_RST = 4'h0;
    localparam logic [3:0] IMK_RST = 4'hF;
    localparam logic [7:0] ZERO8   = 8'h00;
endpackage
`default_nettype wire

/* File: src/mdm_lines.sv */
// modem status and control lines, interrupt pin and host data bus
`default_nettype none
module mdm_lines
    import mdm_pkg::*;
(
    input  wire logic       sys_clk,
    input  wire logic       rstn,
    input  wire logic       master_reset,
    input  wire logic [2:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr_stb,
    input  wire logic       rd_stb,
    output logic [7:0]      rdata,
    input  wire logic [7:0] data_in,
    output logic [7:0]      data_out,
    output logic [7:0]      data_oe,
    output logic            transceiver_disable,
    input  wire logic       cts_n,
    input  wire logic       dsr_n,
    input  wire logic       ring_n,
    input  wire logic       carrier_detect_n,
    input  wire logic       rx_err_evt,
    input  wire logic       rx_data_evt,
    input  wire logic       fifo_mode,
    input  wire logic       thr_empty_evt,
    output logic            dtr_n,
    output logic            rts_n,
    output logic            user_out_a_n,
    output logic            user_out_b_n,
    output logic            irq_out
);
    import mdm_pkg::*;

    logic [7:0] modem_control_reg;
    logic [3:0] ier_r;
    logic [3:0] imk_r;
    logic [3:0] src_r;
    logic [3:0] dflag_r;
    logic [3:0] lvl_r;

    // address match, shared by the read and write decoders
    function automatic logic hit(input logic [2:0] a,
                                 input logic [2:0] r);
        return a == r;
    endfunction

    // levels seen at the pins, active high; loop mode keeps them live
    wire [3:0] lvl_now = {~carrier_detect_n, ~ring_n, ~dsr_n, ~cts_n};
    wire       loop_on = modem_control_reg[MCR_LOOP];

    wire msr_rd = rd_stb && hit(addr, ADDR_MSR);
    wire src_rd = rd_stb && hit(addr, ADDR_SRC);
    wire mcr_wr = wr_stb && hit(addr, ADDR_MCR);
    wire ier_wr = wr_stb && hit(addr, ADDR_IER);
    wire imk_wr = wr_stb && hit(addr, ADDR_IMK);

    // ring flag only on trailing edge of the ring pulse
    wire [3:0] chg;
    assign chg[0] = lvl_now[0] ^ lvl_r[0];
    assign chg[1] = lvl_now[1] ^ lvl_r[1];
    assign chg[2] = lvl_r[2] & ~lvl_now[2];
    assign chg[3] = lvl_now[3] ^ lvl_r[3];

    // set wins over the read-clear so no change is lost
    wire [3:0] dflag_nxt = (msr_rd ? 4'h0 : dflag_r) | chg;

    wire [7:0] msr_val = {lvl_r[3], lvl_r[2], lvl_r[1], lvl_r[0],
                          dflag_r};

    wire modem_pend = |dflag_r;
    wire rxd_ok     = rx_data_evt & fifo_mode;
    wire [3:0] ev_now = {modem_pend, rx_err_evt, thr_empty_evt, rxd_ok};
    wire [3:0] en_ev  = ev_now & ier_r;
    // sticky event status; a read of it clears, a new event wins
    wire [3:0] src_nxt = (src_rd ? 4'h0 : src_r) | en_ev;
    // modem source stays pending while any change flag is set
    wire [3:0] live   = {modem_pend & ier_r[IE_MODEM], src_r[2:0]};
    wire       irq_nxt = |(live & imk_r);

    wire [7:0] rd_mux =
        hit(addr, ADDR_MSR) ? msr_val :
        hit(addr, ADDR_MCR) ? modem_control_reg :
        hit(addr, ADDR_IER) ? {4'h0, ier_r} :
        hit(addr, ADDR_IMK) ? {4'h0, imk_r} :
        hit(addr, ADDR_SRC) ? {4'h0, src_r} :
        hit(addr, ADDR_IIR) ? {7'h00, ~irq_out} : ZERO8;

    // master reset is a synchronous clear on top of the async rstn
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            modem_control_reg <= MCR_RST;
            ier_r             <= IER_RST;
            imk_r             <= IMK_RST;
        end else if (master_reset) begin
            modem_control_reg <= MCR_RST;
            ier_r             <= IER_RST;
            imk_r             <= IMK_RST;
        end else begin
            if (mcr_wr)
                modem_control_reg <= {3'h0, wdata[4:0]};
            if (ier_wr)
                ier_r <= wdata[3:0];
            if (imk_wr)
                imk_r <= wdata[3:0];
        end
    end

    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            lvl_r   <= 4'h0;
            dflag_r <= 4'h0;
            src_r   <= 4'h0;
        end else if (master_reset) begin
            lvl_r   <= lvl_now;
            dflag_r <= 4'h0;
            src_r   <= 4'h0;
        end else begin
            lvl_r   <= lvl_now;
            dflag_r <= dflag_nxt;
            src_r   <= src_nxt;
        end
    end

    // data bus drives only the cycle after a read strobe
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rdata     <= ZERO8;
            data_out  <= ZERO8;
            data_oe   <= ZERO8;
        end else begin
            rdata     <= rd_stb ? rd_mux : ZERO8;
            data_out  <= rd_stb ? rd_mux : ZERO8;
            data_oe   <= {8{rd_stb}};
        end
    end

    // modem control pins are active low and parked high in loop mode or reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            dtr_n               <= 1'b1;
            rts_n               <= 1'b1;
            user_out_a_n        <= 1'b1;
            user_out_b_n        <= 1'b1;
            irq_out             <= 1'b0;
            transceiver_disable <= 1'b1;
        end else begin
            dtr_n        <= master_reset | loop_on |
                            ~modem_control_reg[MCR_DTR];
            rts_n        <= master_reset | loop_on |
                            ~modem_control_reg[MCR_RTS];
            user_out_a_n <= master_reset | loop_on |
                            ~modem_control_reg[MCR_OUTA];
            user_out_b_n <= master_reset | loop_on |
                            ~modem_control_reg[MCR_OUTB];
            irq_out      <= ~master_reset & irq_nxt;
            transceiver_disable <= ~rd_stb;
        end
    end

    // host bus and transceiver control
    a_transceiver_disable_read: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        rd_stb |=> !transceiver_disable && data_oe == 8'hFF)
        else $error("driver disable not low during read");
    a_bus_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !rd_stb |=> data_oe == 8'h00 && transceiver_disable)
        else $error("bus driven outside read");
    a_rdata_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        !rd_stb |=> rdata == ZERO8 && data_out == ZERO8)
        else $error("read data not parked outside read");

    // modem status levels and change flags
    a_dcd_flag: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && lvl_r[3] != ~carrier_detect_n)
        |=> dflag_r[MSR_DDCD])
        else $error("carrier change not flagged");
    a_dsr_flag: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && lvl_r[1] != ~dsr_n)
        |=> dflag_r[MSR_DDSR])
        else $error("data set ready change not flagged");
    a_cts_flag: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && lvl_r[0] != ~cts_n)
        |=> dflag_r[MSR_DCTS])
        else $error("clear to send change not flagged");
    a_ring_flag: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && lvl_r[2] && ring_n)
        |=> dflag_r[MSR_RING_TRAILING_EDGE_FLAG])
        else $error("ring trailing edge not flagged");
    a_ring_lead: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!dflag_r[MSR_RING_TRAILING_EDGE_FLAG] && !(lvl_r[2] && ring_n))
        |=> !dflag_r[MSR_RING_TRAILING_EDGE_FLAG])
        else $error("ring flag set without trailing edge");
    a_dcd_level: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        msr_val[MSR_DCD] == ~$past(carrier_detect_n))
        else $error("carrier level wrong");
    a_dsr_level: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        msr_val[MSR_DSR] == ~$past(dsr_n))
        else $error("data set ready level wrong");
    a_cts_level: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        msr_val[MSR_CTS] == ~$past(cts_n))
        else $error("clear to send level wrong");
    a_ring_level: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        msr_val[MSR_RI] == ~$past(ring_n))
        else $error("ring level wrong");
    a_msr_clear: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (msr_rd && !master_reset && chg == 4'h0) |=> dflag_r == 4'h0)
        else $error("change flags not cleared by read");

    // modem control pins
    a_dtr_pin: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && !loop_on && modem_control_reg[MCR_DTR])
        |=> !dtr_n)
        else $error("terminal ready not active");
    a_dtr_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (master_reset || loop_on || !modem_control_reg[MCR_DTR])
        |=> dtr_n)
        else $error("terminal ready active when it should rest");
    a_rts_pin: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && !loop_on && modem_control_reg[MCR_RTS])
        |=> !rts_n)
        else $error("request to send not active");
    a_rts_idle: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (master_reset || loop_on || !modem_control_reg[MCR_RTS])
        |=> rts_n)
        else $error("request to send active when it should rest");
    a_outa_pin: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && !loop_on && modem_control_reg[MCR_OUTA])
        |=> !user_out_a_n)
        else $error("first user output not active");
    a_outb_pin: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && !loop_on && modem_control_reg[MCR_OUTB])
        |=> !user_out_b_n)
        else $error("second user output not active");
    a_outs_loop: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (loop_on || master_reset) |=> user_out_a_n && user_out_b_n)
        else $error("user outputs active in loop or reset");
    a_outs_clear: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!modem_control_reg[MCR_OUTA] && !modem_control_reg[MCR_OUTB])
        |=> user_out_a_n && user_out_b_n)
        else $error("user outputs active with bits cleared");

    // interrupt pin and master reset
    a_irq_modem: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && modem_pend && ier_r[IE_MODEM] && imk_r[IE_MODEM])
        |=> irq_out)
        else $error("modem interrupt missing");
    a_irq_source: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && (src_r[2:0] & imk_r[2:0]) != 3'h0)
        |=> irq_out)
        else $error("pending source did not raise interrupt");
    a_src_sticky: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        (!master_reset && !src_rd)
        |=> (src_r & $past(src_r)) == $past(src_r))
        else $error("event status lost without a read");
    a_irq_reset: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        master_reset |=> !irq_out)
        else $error("interrupt kept through master reset");
    a_mr_clear: assert property (
        @(posedge sys_clk) disable iff (!rstn)
        master_reset |=> modem_control_reg == MCR_RST &&
                         ier_r == IER_RST && dflag_r == 4'h0)
        else $error("master reset left registers set");
endmodule
`default_nettype wire

/* File: test/mdm_modem_model.sv */
// modem side model driving the four active-low status lines
`default_nettype none
module mdm_modem_model (
    input  wire logic       sys_clk,
    input  wire logic [3:0] req_lvl,
    output logic            cts_n,
    output logic            dsr_n,
    output logic            ring_n,
    output logic            carrier_detect_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // lines only move just after an edge, so the block sees clean levels
    always_ff @(posedge sys_clk) begin
        {carrier_detect_n, ring_n, dsr_n, cts_n} <= req_lvl;
    end
endmodule
`default_nettype wire

/* File: test/testbench.sv */
// self-checking bench for the modem lines and interrupt pin block
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mdm_pkg::*;
    logic       sys_clk, rstn, master_reset, wr_stb, rd_stb, fifo_mode;
    logic [2:0] addr, ev, evk;
    logic [7:0] wdata, d, q, em;
    logic [3:0] req_lvl, ov, nv;
    logic [31:0] lfsr;
    wire  logic [7:0] rdata, data_out, data_oe;
    wire  logic cts_n, dsr_n, ring_n, carrier_detect_n, transceiver_disable;
    wire  logic dtr_n, rts_n, user_out_a_n, user_out_b_n, irq_out;
    wire  logic [7:0] pins;
    int         fails, n_tests, i;
    assign pins = {3'h0, irq_out, user_out_b_n, user_out_a_n, rts_n, dtr_n};
    mdm_lines dut (.sys_clk(sys_clk), .rstn(rstn), .master_reset(master_reset),
        .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .data_in(8'h00), .data_out(data_out),
        .data_oe(data_oe), .transceiver_disable(transceiver_disable),
        .cts_n(cts_n), .dsr_n(dsr_n), .ring_n(ring_n),
        .carrier_detect_n(carrier_detect_n), .rx_err_evt(ev[2]),
        .rx_data_evt(ev[0]), .fifo_mode(fifo_mode), .thr_empty_evt(ev[1]),
        .dtr_n(dtr_n), .rts_n(rts_n), .user_out_a_n(user_out_a_n),
        .user_out_b_n(user_out_b_n), .irq_out(irq_out));
    mdm_modem_model modem (.sys_clk(sys_clk), .req_lvl(req_lvl),
        .cts_n(cts_n), .dsr_n(dsr_n), .ring_n(ring_n),
        .carrier_detect_n(carrier_detect_n));
    function automatic logic [31:0] step(input logic [31:0] x);
        return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
    endfunction
    function automatic logic [7:0] exp_pins(input logic [7:0] m);
        return {4'h0, ~(m[3:0] & {4{~m[4]}})};
    endfunction
    function automatic logic [7:0] exp_msr(input logic [3:0] o, n);
        return {~n, o[3] ^ n[3], ~o[2] & n[2], o[1] ^ n[1], o[0] ^ n[0]};
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge sys_clk);
        {addr, wdata, wr_stb} <= {a, v, 1'b1};
        @(posedge sys_clk);
        wr_stb <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        @(posedge sys_clk);
        {addr, rd_stb} <= {a, 1'b1};
        @(posedge sys_clk);
        rd_stb <= 1'b0;
        #1;
        v = rdata;
        chk({7'h00, transceiver_disable}, 8'h00);
        chk(data_oe, 8'hFF);
    endtask
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one clock times the whole block, modem model included
    initial begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end
    // hang guard: the whole run needs far fewer cycles than this
    initial begin
        #2000000;
        fails++;
        give_verdict();
    end
    initial begin
        {rstn, master_reset, addr, wdata, wr_stb, rd_stb} = '0;
        {ev, fifo_mode, req_lvl} = 8'h0F;
        {fails, n_tests, lfsr} = {32'h0, 32'h0, 32'hF8A4};
        repeat (16) @(posedge sys_clk);
        rstn <= 1'b1;
        tick(1);
        chk(pins, 8'h0F);
        chk({7'h00, transceiver_disable}, 8'h01);
        rd(ADDR_IMK, d);
        chk(d, {4'h0, IMK_RST});
        rd(ADDR_MSR, d);
        for (i = 0; i < 12; i++) begin
            lfsr = step(lfsr);
            d = (i == 0) ? 8'h0F : (i == 1) ? 8'h1F : lfsr[7:0];
            wr(ADDR_MCR, d);
            tick(1);
            chk(pins, exp_pins(d));
            rd(ADDR_MCR, q);
            chk(q, d & 8'h1F);
        end
        $display("test control pins done");
        wr(ADDR_IER, 8'h08);
        ov = 4'hF;
        for (i = 0; i < 12; i++) begin
            lfsr = step(lfsr);
            nv = (i == 0) ? 4'h0 : lfsr[3:0];
            @(posedge sys_clk);
            req_lvl <= nv;
            tick(5);
            em = exp_msr(ov, nv);
            chk({7'h00, irq_out}, {7'h00, |em[3:0]});
            rd(ADDR_MSR, q);
            chk(q, exp_msr(ov, nv));
            tick(2);
            chk({7'h00, irq_out}, 8'h00);
            rd(ADDR_MSR, q);
            chk(q, exp_msr(nv, nv));
            ov = nv;
        end
        $display("test modem status done");
        wr(ADDR_IER, 8'h07);
        for (i = 0; i < 5; i++) begin
            evk = (i >= 3) ? 3'h1 << (i - 3) : 3'h1 << i;
            if (i == 4) wr(ADDR_IMK, 8'h00);
            @(posedge sys_clk);
            {ev, fifo_mode} <= {evk, i != 3};
            @(posedge sys_clk);
            ev <= 3'h0;
            tick(3);
            chk({7'h00, irq_out}, {7'h00, i < 3});
            rd(ADDR_IIR, q);
            chk({7'h00, q[0]}, {7'h00, i >= 3});
            rd(ADDR_SRC, q);
            chk(q & 8'h07, (i != 3) ? {5'h00, evk} : 8'h00);
            tick(2);
            chk({7'h00, irq_out}, 8'h00);
        end
        wr(ADDR_IMK, 8'h0F);
        $display("test interrupt sources done");
        wr(ADDR_MCR, 8'h0F);
        @(posedge sys_clk);
        master_reset <= 1'b1;
        @(posedge sys_clk);
        master_reset <= 1'b0;
        tick(1);
        chk(pins, 8'h0F);
        rd(ADDR_MCR, q);
        chk(q, MCR_RST);
        rd(3'h5, q);
        chk(q, ZERO8);
        $display("test master reset done");
        give_verdict();
    end
endmodule
`default_nettype wire
